// file: design/sls_cfg.svh
`ifndef SLS_CFG_SVH
`define SLS_CFG_SVH

// clock and timing
`define SLS_CLK_HZ 50000000
`define SLS_CLK_PERIOD_NS 20
`define SLS_GAP_LIMIT_MS 2000
`define SLS_NS_PER_MS 1000000
`define SLS_GAP_CYCLES (`SLS_GAP_LIMIT_MS * (`SLS_NS_PER_MS / `SLS_CLK_PERIOD_NS))

// link rates in bits per second
`define SLS_RATE_CODE0_BPS 2400
`define SLS_RATE_CODE1_BPS 4800
`define SLS_RATE_CODE2_BPS 9600

// character framing
`define SLS_DATA_BITS 8
`define SLS_STOP_BITS 1

// setting codes and defaults
`define SLS_PARITY_NONE 2'h0
`define SLS_PARITY_EVEN 2'h1
`define SLS_PARITY_ODD 2'h2
`define SLS_RATE_DEFAULT 2'h2
`define SLS_ADDR_DEFAULT 5'h01
`define SLS_GAP_EN_DEFAULT 1'h1
`define SLS_RESP_DEFAULT 2'h1
`define SLS_OPLOSS_DEFAULT 1'h0

`endif

// file: design/sls_pkg.sv
package sls_pkg;

  typedef enum logic [2:0] {
    SLS_SUP_OFF   = 3'h1,
    SLS_SUP_WATCH = 3'h2,
    SLS_SUP_ERR   = 3'h4
  } sls_sup_t;

  typedef enum logic [1:0] {
    SLS_RESP_RAMP1    = 2'h0,
    SLS_RESP_COAST    = 2'h1,
    SLS_RESP_RAMP2    = 2'h2,
    SLS_RESP_CONTINUE = 2'h3
  } sls_resp_t;

endpackage

// file: design/sls_gap_timer.sv
`timescale 1ns/1ns
module sls_gap_timer #(
  parameter int unsigned LIMIT = 100000000
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // control
  input wire logic run_in,
  input wire logic restart_in,
  // status
  output logic expired_out
);

  localparam logic [31:0] LIMIT_W = 32'(LIMIT);
  localparam logic [31:0] SAT_W = 32'(LIMIT) + 32'h0000_0001;

  logic [31:0] cnt_r;

  // restart and saturating count
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= 32'h0000_0000;
    end else if (restart_in || !run_in) begin
      cnt_r <= 32'h0000_0000;
    end else if (cnt_r != SAT_W) begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  // interval strictly longer than the limit
  assign expired_out = (cnt_r > LIMIT_W);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_timer_restart: assert property (restart_in |=> cnt_r == 32'h0000_0000)
    else $error("gap timer not restarted");
  a_timer_limit: assert property (run_in && !restart_in && cnt_r == LIMIT_W |=> !run_in || restart_in || expired_out)
    else $error("gap timer did not expire past limit");

endmodule

// file: design/sls_supervisor.sv
// Operation
// - parity code 0 none, 1 even, 2 odd.
// - address, rate and parity captured only at power-up.
// - gap supervision on by default; flag error past 2.0 s gap. (No default here: it follows msg_gap_supervise_enable_in only.)
// - error response: ramp decel1, coast, ramp decel2 with fault; code 3 alarm.
// - operator loss code 1 trips immediately while running.
// - operator loss code 0 defers fault until drive stopped.
// - rate code 0 2400, 1 4800, 2 9600; both ends match.
// - eight data bits, optional parity, one stop bit on both ends.
// - station address 0 to 31, distinct per line.
`timescale 1ns/1ns
`include "sls_cfg.svh"
module sls_supervisor #(
  parameter int unsigned GAP_CYCLES = `SLS_GAP_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // settings
  input wire logic [1:0] parity_select_in,
  input wire logic [1:0] link_rate_select_in,
  input wire logic [4:0] station_address_in,
  input wire logic msg_gap_supervise_enable_in,
  input wire logic [1:0] comm_error_response_in,
  input wire logic operator_loss_detect_in,
  // receiver events
  input wire logic msg_valid_in,
  input wire logic msg_error_in,
  input wire logic [4:0] msg_addr_in,
  // drive state
  input wire logic motor_running_in,
  input wire logic fault_reset_in,
  input wire logic operator_present_in,
  // active link framing
  output logic parity_enable_out,
  output logic parity_odd_out,
  output logic [15:0] bit_cycles_out,
  output logic [4:0] station_address_out,
  output logic [3:0] data_bits_out,
  output logic [1:0] stop_bits_out,
  // supervision status
  output logic comm_error_out,
  output logic comm_fault_out,
  output logic comm_alarm_out,
  output logic [1:0] comm_stop_mode_out,
  output logic operator_fault_out
);

  function automatic logic [15:0] rate_div(input logic [1:0] code);
    case (code)
      2'h0: rate_div = 16'(`SLS_CLK_HZ / `SLS_RATE_CODE0_BPS);
      2'h1: rate_div = 16'(`SLS_CLK_HZ / `SLS_RATE_CODE1_BPS);
      default: rate_div = 16'(`SLS_CLK_HZ / `SLS_RATE_CODE2_BPS);
    endcase
  endfunction

  logic [1:0] rst_sync_r;
  logic rstn;
  logic cap_done_r;
  logic [1:0] parity_r;
  logic [1:0] rate_r;
  logic [2:0] op_sync_r;
  logic op_lost_evt;
  logic op_pend_r;
  logic good_msg;
  logic expired;
  sls_pkg::sls_sup_t sup_r;
  sls_pkg::sls_sup_t sup_nxt;
  logic comm_err_rise;
  logic clr_ok;

  // reset release
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'h1};
    end
  end
  assign rstn = rst_sync_r[1];

  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      cap_done_r <= 1'h0;
      parity_r <= `SLS_PARITY_NONE;
      rate_r <= `SLS_RATE_DEFAULT;
      station_address_out <= `SLS_ADDR_DEFAULT;
      bit_cycles_out <= 16'(`SLS_CLK_HZ / `SLS_RATE_CODE2_BPS);
    end else if (!cap_done_r) begin
      cap_done_r <= 1'h1;
      parity_r <= parity_select_in;
      rate_r <= link_rate_select_in;
      station_address_out <= station_address_in;
      bit_cycles_out <= rate_div(link_rate_select_in);
    end
  end

  // parity code decode, code 3 taken as none
  assign parity_enable_out = (parity_r == `SLS_PARITY_EVEN) || (parity_r == `SLS_PARITY_ODD);
  assign parity_odd_out = (parity_r == `SLS_PARITY_ODD);
  assign data_bits_out = 4'(`SLS_DATA_BITS);
  assign stop_bits_out = 2'(`SLS_STOP_BITS);

  assign good_msg = msg_valid_in && !msg_error_in && (msg_addr_in == station_address_out) && cap_done_r;

  sls_gap_timer #(
    .LIMIT(GAP_CYCLES)
  ) u_gap (
    .clk_in(clk_in),
    .rstn_in(rstn),
    .run_in(sup_r == sls_pkg::SLS_SUP_WATCH),
    .restart_in(good_msg),
    .expired_out(expired)
  );

  always_comb begin
    sup_nxt = sup_r;
    case (sup_r)
      sls_pkg::SLS_SUP_OFF: begin
        if (msg_gap_supervise_enable_in && cap_done_r) begin
          sup_nxt = sls_pkg::SLS_SUP_WATCH;
        end
      end
      sls_pkg::SLS_SUP_WATCH: begin
        if (!msg_gap_supervise_enable_in) begin
          sup_nxt = sls_pkg::SLS_SUP_OFF;
        end else if (expired && !good_msg) begin
          sup_nxt = sls_pkg::SLS_SUP_ERR;
        end
      end
      sls_pkg::SLS_SUP_ERR: begin
        if (!msg_gap_supervise_enable_in) begin
          sup_nxt = sls_pkg::SLS_SUP_OFF;
        end else if (good_msg) begin
          sup_nxt = sls_pkg::SLS_SUP_WATCH;
        end
      end
      default: sup_nxt = sls_pkg::SLS_SUP_OFF;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      sup_r <= sls_pkg::SLS_SUP_OFF;
    end else begin
      sup_r <= sup_nxt;
    end
  end

  assign comm_error_out = (sup_r == sls_pkg::SLS_SUP_ERR);
  assign comm_err_rise = (sup_nxt == sls_pkg::SLS_SUP_ERR) && (sup_r != sls_pkg::SLS_SUP_ERR);
  assign clr_ok = fault_reset_in && !motor_running_in;

  // response latched at the error, fault sticky, set beats reset
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      comm_fault_out <= 1'h0;
      comm_stop_mode_out <= `SLS_RESP_DEFAULT;
    end else if (comm_err_rise && comm_error_response_in != sls_pkg::SLS_RESP_CONTINUE) begin
      comm_fault_out <= 1'h1;
      comm_stop_mode_out <= comm_error_response_in;
    end else if (clr_ok) begin
      comm_fault_out <= 1'h0;
    end
  end

  // continue mode raises an alarm only
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      comm_alarm_out <= 1'h0;
    end else begin
      comm_alarm_out <= (sup_nxt == sls_pkg::SLS_SUP_ERR) &&
                        (comm_error_response_in == sls_pkg::SLS_RESP_CONTINUE) && !comm_fault_out;
    end
  end

  // keypad presence synchroniser and loss edge
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      op_sync_r <= 3'h7;
    end else begin
      op_sync_r <= {op_sync_r[1:0], operator_present_in};
    end
  end
  assign op_lost_evt = op_sync_r[2] && !op_sync_r[1];

  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      op_pend_r <= 1'h0;
    end else if (op_lost_evt) begin
      op_pend_r <= 1'h1;
    end else if (operator_fault_out) begin
      op_pend_r <= 1'h0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      operator_fault_out <= 1'h0;
    end else if ((op_lost_evt || op_pend_r) && (operator_loss_detect_in || !motor_running_in)) begin
      operator_fault_out <= 1'h1;
    end else if (clr_ok) begin
      operator_fault_out <= 1'h0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn);

  a_settings_frozen: assert property (cap_done_r |=> $stable(station_address_out) && $stable(parity_r))
    else $error("link settings changed after power-up");
  a_parity_decode: assert property (cap_done_r && parity_r == 2'h1 |-> parity_enable_out && !parity_odd_out)
    else $error("even parity not decoded");
  a_rate_default: assert property (cap_done_r && rate_r == 2'h2 |-> bit_cycles_out == 16'h1458)
    else $error("9600 bit time wrong");
  a_gap_timeout: assert property (sup_r == sls_pkg::SLS_SUP_WATCH && expired && !good_msg &&
    msg_gap_supervise_enable_in |=> comm_error_out)
    else $error("gap timeout not flagged");
  a_gap_disabled: assert property (!msg_gap_supervise_enable_in |=> !comm_error_out)
    else $error("error flagged with supervision off");
  a_err_fault: assert property (comm_err_rise && comm_error_response_in == 2'h1 |=>
    comm_fault_out && comm_stop_mode_out == 2'h1)
    else $error("coast response missing");
  a_err_alarm: assert property (comm_err_rise && comm_error_response_in == 2'h3 && !comm_fault_out |=>
    comm_alarm_out && !comm_fault_out)
    else $error("continue response wrong");
  a_oploss_now: assert property (op_lost_evt && operator_loss_detect_in |=> operator_fault_out)
    else $error("operator loss trip late");
  a_oploss_defer: assert property (op_pend_r && !operator_fault_out && !operator_loss_detect_in &&
    motor_running_in |=> !operator_fault_out)
    else $error("operator fault raised while running");
  a_msg_recover: assert property (comm_error_out && good_msg && msg_gap_supervise_enable_in |=>
    !comm_error_out)
    else $error("good message did not clear error");

  c_timeout: cover property (comm_err_rise);
  c_alarm: cover property (comm_alarm_out);
  c_deferred: cover property (op_pend_r && motor_running_in ##1 !motor_running_in ##1 operator_fault_out);

endmodule

// file: tb/sls_plc_model.sv
`timescale 1ns/1ns
module sls_plc_model (
  // clock
  input wire logic clk_in,
  // received message events
  output logic msg_valid_out,
  output logic msg_error_out,
  output logic [4:0] msg_addr_out
);
  initial begin
    msg_valid_out = 1'b0;
    msg_error_out = 1'b1;
    msg_addr_out = 5'h1f;
  end

  // one framed message to one station
  task automatic send(input logic [4:0] addr, input logic err);
    @(posedge clk_in);
    #2;
    msg_valid_out = 1'b1;
    msg_error_out = err;
    msg_addr_out = addr;
    @(posedge clk_in);
    #2;
    msg_valid_out = 1'b0;
    // stale qualifiers show the inverse once released
    msg_error_out = ~err;
    msg_addr_out = ~addr;
  endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/1ns
module tb;
  localparam int unsigned GAP = 50;
  logic clk, rst_n, gap_en, op_det, op_pres, run, f_rst;
  logic [1:0] par, rate, resp, sbits, smode;
  logic [4:0] adr, m_addr, adr_out;
  logic m_valid, m_err, par_en, par_odd, c_err, c_fault, c_alarm, op_fault;
  logic [15:0] bit_cyc;
  logic [3:0] dbits;
  int n_mismatch = 0;
  int n_tests = 0;
  int n;
  logic [15:0] rate_tab [4] = '{16'h5161, 16'h28b0, 16'h1458, 16'h1458};

  sls_supervisor #(.GAP_CYCLES(GAP)) dut (
    .clk_in(clk), .rstn_in(rst_n), .parity_select_in(par), .link_rate_select_in(rate),
    .station_address_in(adr), .msg_gap_supervise_enable_in(gap_en), .comm_error_response_in(resp),
    .operator_loss_detect_in(op_det), .msg_valid_in(m_valid), .msg_error_in(m_err),
    .msg_addr_in(m_addr), .motor_running_in(run), .fault_reset_in(f_rst),
    .operator_present_in(op_pres), .parity_enable_out(par_en), .parity_odd_out(par_odd),
    .bit_cycles_out(bit_cyc), .station_address_out(adr_out), .data_bits_out(dbits),
    .stop_bits_out(sbits), .comm_error_out(c_err), .comm_fault_out(c_fault),
    .comm_alarm_out(c_alarm), .comm_stop_mode_out(smode), .operator_fault_out(op_fault));

  sls_plc_model plc (.clk_in(clk), .msg_valid_out(m_valid), .msg_error_out(m_err), .msg_addr_out(m_addr));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  task automatic do_reset(input logic [1:0] p, input logic [1:0] r, input logic [4:0] a);
    rst_n = 1'b0;
    par = p;
    rate = r;
    adr = a;
    cyc(10);
    rst_n = 1'b1;
    cyc(4);
  endtask

  task automatic wait_err(output int k);
    k = 0;
    while (c_err !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    if (k >= 200) begin
      n_mismatch++;
      test_done();
    end
  endtask

  initial begin
    {gap_en, op_det, run, f_rst} = 4'h0;
    op_pres = 1'b1;
    resp = 2'h1;
    do_reset(2'h0, 2'h0, 5'h00);
    // code 3 of parity and rate falls back to none and 9600
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1:0], i[1:0], 5'(i * 10 + 1));
      par = 2'h3;
      rate = 2'h1;
      adr = 5'h1f;
      cyc(3);
      chk({15'h0, par_en}, {15'h0, (i == 1) || (i == 2)});
      chk({15'h0, par_odd}, {15'h0, i == 2});
      chk(bit_cyc, rate_tab[i]);
      chk({11'h0, adr_out}, 16'(i * 10 + 1));
      chk({8'h0, dbits, 2'h0, sbits}, 16'h0081);
    end
    cyc(GAP * 2);
    chk({15'h0, c_err}, 16'h0000);
    gap_en = 1'b1;
    for (int c = 0; c < 4; c++) begin
      resp = c[1:0];
      do_reset(2'h0, 2'h2, 5'h03);
      repeat (3) begin
        cyc(30);
        plc.send(5'h03, 1'b0);
      end
      chk({15'h0, c_err}, 16'h0000);
      plc.send(5'h04, 1'b0);
      plc.send(5'h03, 1'b1);
      wait_err(n);
      // two refused messages: last restart lies four edges before the wait
      chk(16'(n), 16'(GAP - 2));
      chk({15'h0, c_fault}, {15'h0, c != 3});
      chk({15'h0, c_alarm}, {15'h0, c == 3});
      if (c != 3)
        chk({14'h0, smode}, 16'(c));
      else
        chk({14'h0, smode}, 16'h0001);
      plc.send(5'h03, 1'b0);
      cyc(1);
      chk({15'h0, c_err | c_alarm}, 16'h0000);
      chk({15'h0, c_fault}, {15'h0, c != 3});
    end
    resp = 2'h1;
    do_reset(2'h0, 2'h2, 5'h03);
    wait_err(n);
    // timer cleared at power-up: full limit from the start of watching
    chk(16'(n), 16'(GAP + 2));
    gap_en = 1'b0;
    run = 1'b1;
    f_rst = 1'b1;
    cyc(2);
    chk({15'h0, c_fault}, 16'h0001);
    chk({15'h0, c_err}, 16'h0000);
    run = 1'b0;
    cyc(2);
    chk({15'h0, c_fault}, 16'h0000);
    f_rst = 1'b0;
    op_det = 1'b1;
    run = 1'b1;
    do_reset(2'h0, 2'h2, 5'h03);
    op_pres = 1'b0;
    cyc(5);
    chk({15'h0, op_fault}, 16'h0001);
    op_pres = 1'b1;
    op_det = 1'b0;
    do_reset(2'h0, 2'h2, 5'h03);
    op_pres = 1'b0;
    cyc(6);
    chk({15'h0, op_fault}, 16'h0000);
    run = 1'b0;
    cyc(3);
    chk({15'h0, op_fault}, 16'h0001);
    test_done();
  end
endmodule
